// ### inc/spicsf_pkg.sv
// Package with register map, field layout and reset values of the serial port control/status block
//
// Summary of operation
// - Transfer-done flag set at end of transfer; only software ever clears it.
// - With interrupts enabled, any set transfer-done flag raises the port interrupt.
// - Data write during a busy transfer sets write-collision flag and interrupt.
// - Select low, master enabled and wiring mode 01 set mode-fault flag.
// - Last bit arriving while receive buffer unread sets receive-overrun flag.
// - Receive overrun is detected only while operating as a slave.
// - Wiring mode 00 is three-wire operation; select is not routed to a pin.
// - Wiring mode 01, the reset value, takes slave select as an input.
// - Wiring mode 1x drives slave select out at the mode's low bit level while the port is enabled.
// - Software writing the transmit buffer clears the buffer-empty indication.
// - Buffer byte moving into the shift register sets the buffer-empty indication.
// - Port enable bit 0 disables the serial port, 1 enables it.
// - Register sits at special-function address f8, page 00, bit addressable.
package spicsf_pkg;
  localparam logic [7:0] CSR_ADDR = 8'hf8;
  localparam logic [7:0] CSR_PAGE = 8'h00;
  localparam logic [7:0] CSR_RESET = 8'h06;
  // Bit positions inside serial_port_control_status
  localparam int BIT_DONE = 7;
  localparam int BIT_WRITE_COLLISION_FLAG = 6;
  localparam int BIT_MODE_FAULT_FLAG = 5;
  localparam int BIT_OVRN = 4;
  localparam int BIT_MODE_HI = 3;
  localparam int BIT_MODE_LO = 2;
  localparam int BIT_TXE = 1;
  localparam int BIT_EN = 0;
  // Wiring mode encodings
  localparam logic [1:0] MODE_3WIRE = 2'h0;
  localparam logic [1:0] MODE_4WIRE_IN = 2'h1;
endpackage

// ### rtl/spicsf_ctrl.sv
// Control and status register of the byte-wide serial port, with flags, select wiring and interrupt
`timescale 1ns/1ps
module spicsf_ctrl
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_page,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_bit_wr,
  input wire logic [2:0] i_bit_sel,
  input wire logic i_bit_val,
  input wire logic i_data_wr,
  input wire logic i_xfer_busy,
  input wire logic i_xfer_done,
  input wire logic i_last_bit,
  input wire logic i_rx_unread,
  input wire logic i_shift_load,
  input wire logic i_master_enable,
  input wire logic i_int_enable,
  input wire logic i_slave_select_n,
  output logic [7:0] o_sfr_rdata,
  output logic o_data_accept,
  output logic o_port_enable,
  output logic o_slave_sel_n,
  output logic o_slave_select_n,
  output logic o_slave_select_oe,
  output logic o_select_routed,
  output logic o_irq
);

  // Register state
  logic done_flag;
  logic write_collision_flag_flag;
  logic mode_fault_flag_flag;
  logic ovrn_flag;
  logic [1:0] wiring_mode;
  logic tx_empty;
  logic port_en;
  logic [7:0] rdata;
  logic accept;
  logic irq;
  logic sel_int_n;
  logic sel_out_n;
  logic sel_oe;
  logic routed;
  logic next_done_flag;
  logic next_write_collision_flag_flag;
  logic next_mode_fault_flag_flag;
  logic next_ovrn_flag;
  logic [1:0] next_wiring_mode;
  logic next_tx_empty;
  logic next_port_en;
  logic [7:0] next_rdata;
  logic next_accept;
  logic next_irq;
  logic next_sel_int_n;
  logic next_sel_out_n;
  logic next_sel_oe;
  logic next_routed;

  // Two-stage synchroniser for the select pin; only the second stage is read
  logic sel_meta;
  logic sel_sync;

  // Decoded accesses and the current register image
  logic csr_hit;
  logic byte_wr;
  logic bit_wr;
  logic [7:0] csr_now;
  logic [7:0] wmask;
  logic [7:0] wval;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sel_meta <= 1'b1;
      sel_sync <= 1'b1;
    end
    else
    begin
      sel_meta <= i_slave_select_n;
      sel_sync <= sel_meta;
    end
  end

  // Address decode: one register on one page, byte or bit access
  always_comb
  begin
    csr_hit = (i_sfr_addr == spicsf_pkg::CSR_ADDR) && (i_sfr_page == spicsf_pkg::CSR_PAGE);
    byte_wr = csr_hit && i_sfr_wr;
    bit_wr = csr_hit && i_bit_wr && !i_sfr_wr;
    csr_now = {done_flag, write_collision_flag_flag, mode_fault_flag_flag, ovrn_flag, wiring_mode, tx_empty, port_en};
    // Mask marks the bits touched by this write, value holds what is written to them
    wmask = 8'h00;
    wval = 8'h00;
    if (byte_wr)
    begin
      wmask = 8'hff;
      wval = i_sfr_wdata;
    end
    else if (bit_wr)
    begin
      wmask[i_bit_sel] = 1'b1;
      wval[i_bit_sel] = i_bit_val;
    end
  end

  // Next register values; hardware set of a flag wins over a software clear, an accepted data write wins over shift load
  always_comb
  begin
    next_accept = 1'b0;
    next_tx_empty = tx_empty;
    // Writes of 1 to a flag are ignored so software cannot fake an event
    next_done_flag = done_flag && !(wmask[spicsf_pkg::BIT_DONE] && !wval[spicsf_pkg::BIT_DONE]);
    next_write_collision_flag_flag = write_collision_flag_flag && !(wmask[spicsf_pkg::BIT_WRITE_COLLISION_FLAG] && !wval[spicsf_pkg::BIT_WRITE_COLLISION_FLAG]);
    next_mode_fault_flag_flag = mode_fault_flag_flag && !(wmask[spicsf_pkg::BIT_MODE_FAULT_FLAG] && !wval[spicsf_pkg::BIT_MODE_FAULT_FLAG]);
    next_ovrn_flag = ovrn_flag && !(wmask[spicsf_pkg::BIT_OVRN] && !wval[spicsf_pkg::BIT_OVRN]);
    next_wiring_mode = wiring_mode;
    next_port_en = port_en;
    if (wmask[spicsf_pkg::BIT_MODE_HI])
    begin
      next_wiring_mode[1] = wval[spicsf_pkg::BIT_MODE_HI];
    end
    if (wmask[spicsf_pkg::BIT_MODE_LO])
    begin
      next_wiring_mode[0] = wval[spicsf_pkg::BIT_MODE_LO];
    end
    if (wmask[spicsf_pkg::BIT_EN])
    begin
      next_port_en = wval[spicsf_pkg::BIT_EN];
    end
    // Events only count while the port is enabled
    if (port_en)
    begin
      if (i_xfer_done)
      begin
        next_done_flag = 1'b1;
      end
      if (i_data_wr && i_xfer_busy)
      begin
        next_write_collision_flag_flag = 1'b1;
      end
      if (!sel_sync && i_master_enable && (wiring_mode == spicsf_pkg::MODE_4WIRE_IN))
      begin
        next_mode_fault_flag_flag = 1'b1;
      end
      if (i_last_bit && i_rx_unread && !i_master_enable)
      begin
        next_ovrn_flag = 1'b1;
      end
      if (i_shift_load)
      begin
        next_tx_empty = 1'b1;
      end
      // Colliding write is dropped so the shifting byte stays intact
      if (i_data_wr && !i_xfer_busy)
      begin
        next_accept = 1'b1;
        next_tx_empty = 1'b0;
      end
    end
    // One interrupt line for all four events
    next_irq = i_int_enable && (next_done_flag || next_write_collision_flag_flag || next_mode_fault_flag_flag || next_ovrn_flag);
    // Select wiring: pin input, unrouted, or driven from the mode's low bit
    next_routed = 1'b1;
    next_sel_oe = 1'b0;
    next_sel_out_n = 1'b1;
    next_sel_int_n = 1'b1;
    if (next_wiring_mode == spicsf_pkg::MODE_3WIRE)
    begin
      next_routed = 1'b0;
      next_sel_int_n = 1'b0;
    end
    else if (next_wiring_mode == spicsf_pkg::MODE_4WIRE_IN)
    begin
      next_sel_int_n = sel_sync;
    end
    else
    begin
      next_sel_oe = next_port_en;
      next_sel_out_n = next_wiring_mode[0];
    end
    // Reads return the live image; unmatched addresses read zero
    next_rdata = (csr_hit && i_sfr_rd) ? csr_now : 8'h00;
  end

  // Register stage; outputs come straight from these flops
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      done_flag <= spicsf_pkg::CSR_RESET[spicsf_pkg::BIT_DONE];
      write_collision_flag_flag <= spicsf_pkg::CSR_RESET[spicsf_pkg::BIT_WRITE_COLLISION_FLAG];
      mode_fault_flag_flag <= spicsf_pkg::CSR_RESET[spicsf_pkg::BIT_MODE_FAULT_FLAG];
      ovrn_flag <= spicsf_pkg::CSR_RESET[spicsf_pkg::BIT_OVRN];
      wiring_mode <= spicsf_pkg::CSR_RESET[spicsf_pkg::BIT_MODE_HI:spicsf_pkg::BIT_MODE_LO];
      tx_empty <= spicsf_pkg::CSR_RESET[spicsf_pkg::BIT_TXE];
      port_en <= spicsf_pkg::CSR_RESET[spicsf_pkg::BIT_EN];
      rdata <= 8'h00;
      accept <= 1'b0;
      irq <= 1'b0;
      sel_int_n <= 1'b1;
      sel_out_n <= 1'b1;
      sel_oe <= 1'b0;
      routed <= 1'b1;
    end
    else
    begin
      done_flag <= next_done_flag;
      write_collision_flag_flag <= next_write_collision_flag_flag;
      mode_fault_flag_flag <= next_mode_fault_flag_flag;
      ovrn_flag <= next_ovrn_flag;
      wiring_mode <= next_wiring_mode;
      tx_empty <= next_tx_empty;
      port_en <= next_port_en;
      rdata <= next_rdata;
      accept <= next_accept;
      irq <= next_irq;
      sel_int_n <= next_sel_int_n;
      sel_out_n <= next_sel_out_n;
      sel_oe <= next_sel_oe;
      routed <= next_routed;
    end
  end

  // Output wiring
  assign o_sfr_rdata = rdata;
  assign o_data_accept = accept;
  assign o_port_enable = port_en;
  assign o_slave_sel_n = sel_int_n;
  assign o_slave_select_n = sel_out_n;
  assign o_slave_select_oe = sel_oe;
  assign o_select_routed = routed;
  assign o_irq = irq;

endmodule

// ### bench/spicsf_ctrl_properties.sv
// Concurrent checks on the control/status block ports
`timescale 1ns/1ps
module spicsf_ctrl_properties
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_sfr_rd,
  input wire logic i_data_wr,
  input wire logic i_xfer_busy,
  input wire logic i_xfer_done,
  input wire logic i_last_bit,
  input wire logic i_rx_unread,
  input wire logic i_master_enable,
  input wire logic i_int_enable,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_data_accept,
  input wire logic o_port_enable,
  input wire logic o_slave_sel_n,
  input wire logic o_slave_select_oe,
  input wire logic o_select_routed,
  input wire logic o_irq
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Interrupt enable held over the answer cycle, so a masked irq never fires these
  sequence s_ie;
    i_int_enable ##1 i_int_enable;
  endsequence
  property p_done_irq;
    (o_port_enable && i_xfer_done) ##0 s_ie |-> o_irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("no irq after done");
  property p_ovrn_irq;
    (o_port_enable && i_last_bit && i_rx_unread && !i_master_enable) ##0 s_ie |-> o_irq;
  endproperty
  a_ovrn_irq: assert property (p_ovrn_irq) else $error("no irq after overrun");
  property p_mode_fault_flag_irq;
    (o_port_enable && i_master_enable && o_select_routed && !o_slave_sel_n) ##0 s_ie ##1 i_int_enable |-> o_irq;
  endproperty
  a_mode_fault_flag_irq: assert property (p_mode_fault_flag_irq) else $error("no irq on mode fault");
  property p_coll;
    o_port_enable && i_data_wr && i_xfer_busy |=> !o_data_accept;
  endproperty
  a_coll: assert property (p_coll) else $error("colliding write accepted");
  property p_acc;
    o_port_enable && i_data_wr && !i_xfer_busy |=> o_data_accept;
  endproperty
  a_acc: assert property (p_acc) else $error("data write lost");
  property p_off;
    !o_port_enable && i_data_wr |=> !o_data_accept;
  endproperty
  a_off: assert property (p_off) else $error("disabled port accepted");
  property p_3wire;
    !o_select_routed |-> !o_slave_sel_n && !o_slave_select_oe;
  endproperty
  a_3wire: assert property (p_3wire) else $error("select used in three-wire");
  property p_rd_idle;
    !i_sfr_rd |=> o_sfr_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule
bind spicsf_ctrl spicsf_ctrl_properties u_chk (
  .i_clk(i_clk),
  .i_rstn(i_rstn),
  .i_sfr_rd(i_sfr_rd),
  .i_data_wr(i_data_wr),
  .i_xfer_busy(i_xfer_busy),
  .i_xfer_done(i_xfer_done),
  .i_last_bit(i_last_bit),
  .i_rx_unread(i_rx_unread),
  .i_master_enable(i_master_enable),
  .i_int_enable(i_int_enable),
  .o_sfr_rdata(o_sfr_rdata),
  .o_data_accept(o_data_accept),
  .o_port_enable(o_port_enable),
  .o_slave_sel_n(o_slave_sel_n),
  .o_slave_select_oe(o_slave_select_oe),
  .o_select_routed(o_select_routed),
  .o_irq(o_irq)
);

// ### bench/spicsf_far_end.sv
// Far master model driving the select pin while the port leaves it undriven
`timescale 1ns/1ps
module spicsf_far_end
(
  input wire logic i_sel_low,
  input wire logic i_dev_oe,
  input wire logic i_dev_level,
  output logic o_pin_n
);
  // Device drive wins when enabled, otherwise the far master drives its select
  assign o_pin_n = i_dev_oe ? i_dev_level : !i_sel_low;
endmodule

// ### bench/tb_spicsf_ctrl.sv
// Self-checking bench for the control/status block
`timescale 1ns/1ps
module tb_spicsf_ctrl;
  logic i_clk = 0, i_rstn = 0, i_sfr_wr = 0, i_sfr_rd = 0, i_bit_wr = 0, i_bit_val = 0, i_xfer_busy = 0;
  logic i_rx_unread = 0, i_master_enable = 0, i_int_enable = 1, sel_low = 0, i_slave_select_n;
  logic [7:0] i_sfr_page = 0, i_sfr_wdata = 0, o_sfr_rdata;
  logic [2:0] i_bit_sel = 0;
  logic [7:0] i_sfr_addr = 8'hf8;
  logic [3:0] ev = 0;
  logic o_data_accept, o_port_enable, o_slave_sel_n, o_slave_select_n, o_slave_select_oe, o_select_routed, o_irq;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  // Event pulses share one vector: 3 done, 2 data write, 1 last bit, 0 shift load
  spicsf_ctrl dut (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_sfr_addr(i_sfr_addr),
    .i_sfr_page(i_sfr_page),
    .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd),
    .i_sfr_wdata(i_sfr_wdata),
    .i_bit_wr(i_bit_wr),
    .i_bit_sel(i_bit_sel),
    .i_bit_val(i_bit_val),
    .i_data_wr(ev[2]),
    .i_xfer_busy(i_xfer_busy),
    .i_xfer_done(ev[3]),
    .i_last_bit(ev[1]),
    .i_rx_unread(i_rx_unread),
    .i_shift_load(ev[0]),
    .i_master_enable(i_master_enable),
    .i_int_enable(i_int_enable),
    .i_slave_select_n(i_slave_select_n),
    .o_sfr_rdata(o_sfr_rdata),
    .o_data_accept(o_data_accept),
    .o_port_enable(o_port_enable),
    .o_slave_sel_n(o_slave_sel_n),
    .o_slave_select_n(o_slave_select_n),
    .o_slave_select_oe(o_slave_select_oe),
    .o_select_routed(o_select_routed),
    .o_irq(o_irq)
  );
  spicsf_far_end far (.i_sel_low(sel_low), .i_dev_oe(o_slave_select_oe), .i_dev_level(o_slave_select_n),
    .o_pin_n(i_slave_select_n));
  initial forever #12.5 i_clk = ~i_clk;
  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic step(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] d);
    i_sfr_wdata = d;
    i_sfr_wr = 1;
    step();
    i_sfr_wr = 0;
  endtask
  task automatic wbit(input logic [2:0] b, input logic v);
    i_bit_sel = b;
    i_bit_val = v;
    i_bit_wr = 1;
    step();
    i_bit_wr = 0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] e);
    i_sfr_rd = 1;
    step();
    i_sfr_rd = 0;
    chk("csr", e, o_sfr_rdata);
  endtask
  task automatic pulse(input logic [3:0] e);
    ev = e;
    step();
    ev = 0;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard; the sequence needs about 65 cycles
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    step(12);
    i_rstn = 1;
    rdc(8'h06);
    // Idle edge so the read strobe is never dropped and raised in one time step
    step();
    i_sfr_page = 1;
    rdc(8'h00);
    i_sfr_page = 0;
    wb(8'h07);
    chk("enable", 1, o_port_enable);
    step();
    // A byte write to a neighbouring address must not touch the register
    i_sfr_addr = 8'hf9;
    wb(8'h00);
    i_sfr_addr = 8'hf8;
    chk("enable", 1, o_port_enable);
    pulse(4'h4);
    chk("accept", 1, o_data_accept);
    rdc(8'h05);
    pulse(4'h1);
    rdc(8'h07);
    i_xfer_busy = 1;
    pulse(4'h4);
    chk("accept", 0, o_data_accept);
    i_xfer_busy = 0;
    rdc(8'h47);
    pulse(4'h8);
    rdc(8'hc7);
    chk("irq", 1, o_irq);
    wbit(6, 0);
    step();
    // Writing 1 to a clear flag must leave it clear
    wbit(6, 1);
    step();
    wbit(7, 1);
    rdc(8'h87);
    i_int_enable = 0;
    step();
    chk("irq", 0, o_irq);
    i_int_enable = 1;
    wb(8'h07);
    step();
    chk("irq", 0, o_irq);
    i_rx_unread = 1;
    pulse(4'h2);
    rdc(8'h17);
    wb(8'h07);
    i_master_enable = 1;
    pulse(4'h2);
    rdc(8'h07);
    sel_low = 1;
    step(5);
    chk("select", 0, o_slave_sel_n);
    rdc(8'h27);
    sel_low = 0;
    step(4);
    wb(8'h03);
    sel_low = 1;
    step(5);
    chk("routed", 0, o_select_routed);
    rdc(8'h03);
    sel_low = 0;
    wb(8'h0d);
    step();
    chk("pin", 1, {o_slave_select_oe, i_slave_select_n} == 2'h3);
    wb(8'h09);
    step();
    chk("pin", 0, i_slave_select_n);
    chk("drive", 0, o_slave_select_n);
    wb(8'h04);
    // Disabled port: data write not accepted, done event ignored, buffer-empty stays 1
    pulse(4'h4);
    chk("accept", 0, o_data_accept);
    pulse(4'h8);
    rdc(8'h06);
    end_of_test();
  end
endmodule
